// File: dv/mprf_ctrl_model.sv
/*
 * Controller model: free-running link clock, read commands, output log.
 * Assumes SYS_CLK comes from the bench, which reads the log by hierarchy.
 */
`timescale 1ns/1ps
module mprf_ctrl_model (
    input  wire logic        SYS_CLK,
    input  wire logic [19:0] DQ,
    input  wire logic        DQ_OE_N,
    input  wire logic        DQS,
    input  wire logic        DQS_OE_N,
    output logic             LINK_CK   = 1'h0,
    output logic             RD_CMD    = 1'h0,
    output logic [1:0]       BANK_ADDR = 2'h0,
    output logic             BC4       = 1'h0,
    output logic             A2        = 1'h0
);
    // ****************************************************************
    // Link clock and output log
    // ****************************************************************
    logic [22:0] lg [0:4095];
    int          h     = 0;
    int          cap_h = 0;
    logic [1:0]  cnt   = 2'h0;

    // Log just before each toggle, the latest moment the previous UI is settled
    always @(negedge SYS_CLK) begin
        cnt <= cnt + 2'h1;
        if (cnt == 2'h3) begin
            lg[h]   <= {DQ_OE_N, DQS_OE_N, DQS, DQ};
            h       <= h + 1;
            LINK_CK <= ~LINK_CK;
        end
    end

    // Command spans one rise; returning after three falls keeps four clocks spacing
    task automatic rd(input logic [1:0] ba, input logic bc, input logic a2v);
        @(negedge LINK_CK);
        RD_CMD    = 1'h1;
        BANK_ADDR = ba;
        BC4       = bc;
        A2        = a2v;
        cap_h     = h + 1;
        @(negedge LINK_CK);
        RD_CMD    = 1'h0;
        BANK_ADDR = ~ba; // Released lines show no stale value
        BC4       = ~bc;
        A2        = ~a2v;
        repeat (2) @(negedge LINK_CK);
    endtask
endmodule

// File: dv/tb_top.sv
/*
 * Bench for the readout formatter: row table of formats, then awkward cases.
 * Assumes mprf_ctrl_model drives the link side and logs every half clock.
 */
`timescale 1ns/1ps
module tb_top
    import mprf_pkg::*;
();
    // ****************************************************************
    // Signals and instances
    // ****************************************************************
    localparam int RL = 4;
    localparam int MD = 2;
    typedef struct packed {
        logic [1:0] fmt;
        logic [1:0] pg;
        logic [1:0] ba;
        logic       bc;
        logic       a2;
        logic       pre;
    } mprf_row_t;
    logic        SYS_CLK = 1'h0;
    logic        SRST    = 1'h1;
    logic        MPR_EN  = 1'h0;
    logic [1:0]  RD_FMT  = 2'h0;
    logic [1:0]  PAGE    = 2'h0;
    logic        PRE2    = 1'h0;
    logic [7:0]  loc [4] = '{8'h7f, 8'hc3, 8'h96, 8'h1e};
    logic        LINK_CK, RD_CMD, BC4, A2, DQ_OE_N, DQS_O, DQS_OE_N, CORE_READY;
    logic [1:0]  BANK_ADDR;
    logic [15:0] DQ_O;
    logic [3:0]  dq4;
    int          num_errors = 0;
    int          n_compared = 0;
    int          c;
    int          cb [4];
    mprf_row_t   rows [11];

    mprf_readout #(.DQ_W(16), .READ_LAT(RL), .MOD_DLY(MD)) dut_u (
        .SYS_CLK(SYS_CLK), .SRST(SRST), .LINK_CK(LINK_CK), .RD_CMD(RD_CMD),
        .BANK_ADDR(BANK_ADDR), .BC4(BC4), .A2(A2), .MPR_EN(MPR_EN), .RD_FMT(RD_FMT),
        .PAGE(PAGE), .PRE2(PRE2), .LOC0(loc[0]), .LOC1(loc[1]), .LOC2(loc[2]),
        .LOC3(loc[3]), .DQ_O(DQ_O), .DQ_OE_N(DQ_OE_N), .DQS_O(DQS_O),
        .DQS_OE_N(DQS_OE_N), .CORE_READY(CORE_READY));
    // Narrow device shares every input with the wide one
    mprf_readout #(.DQ_W(4), .READ_LAT(RL), .MOD_DLY(MD)) dut_x4 (
        .SYS_CLK(SYS_CLK), .SRST(SRST), .LINK_CK(LINK_CK), .RD_CMD(RD_CMD),
        .BANK_ADDR(BANK_ADDR), .BC4(BC4), .A2(A2), .MPR_EN(MPR_EN), .RD_FMT(RD_FMT),
        .PAGE(PAGE), .PRE2(PRE2), .LOC0(loc[0]), .LOC1(loc[1]), .LOC2(loc[2]),
        .LOC3(loc[3]), .DQ_O(dq4), .DQ_OE_N(), .DQS_O(), .DQS_OE_N(), .CORE_READY());
    mprf_ctrl_model ctl_u (.SYS_CLK(SYS_CLK), .DQ({dq4, DQ_O}), .DQ_OE_N(DQ_OE_N),
        .DQS(DQS_O), .DQS_OE_N(DQS_OE_N), .LINK_CK(LINK_CK), .RD_CMD(RD_CMD),
        .BANK_ADDR(BANK_ADDR), .BC4(BC4), .A2(A2));

    // System clock
    initial forever #50 SYS_CLK = ~SYS_CLK;

    // ****************************************************************
    // Compare, wait and expectation helpers
    // ****************************************************************
    task automatic cmp_v(input string nm, input logic [19:0] e, input logic [19:0] g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic cmp_b(input string nm, input logic e, input logic g);
        cmp_v(nm, {19'h0, e}, {19'h0, g});
    endtask
    task automatic conclude();
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    // Bounded wait on the link edge count; a hang ends the run
    task automatic wait_h(input int t);
        int n;
        n = 0;
        while (ctl_u.h < t && n < 2000) begin
            @(negedge SYS_CLK);
            n++;
        end
        if (n >= 2000) begin
            num_errors++;
            $display("MISMATCH wait exp done got timeout");
            conclude();
        end
    endtask
    function automatic logic [15:0] exp_dq(mprf_row_t r, int ui);
        logic [15:0] v;
        int          b;
        b = 7 - ui - ((r.bc && r.a2) ? 4 : 0);
        for (int i = 0; i < 16; i++) begin
            if (r.fmt == FMT_PARALLEL && r.pg == PAGE_ZERO)
                v[i] = loc[0][7 - i % 8];
            else if (r.fmt == FMT_STAGGER && r.pg == PAGE_ZERO)
                v[i] = loc[(r.ba + i % 4) % 4][b];
            else
                v[i] = loc[r.ba][b];
        end
        return v;
    endfunction
    // One burst: data per UI, strobe toggling, preamble before, release after
    task automatic chk_burst(input mprf_row_t r, input int cap, input bit prv, input bit nxt);
        int          d;
        int          p;
        logic [22:0] s;
        logic [15:0] e;
        d = cap + 2 * RL;
        p = r.pre ? 4 : 2;
        for (int u = 0; u < 8; u++) begin
            s = ctl_u.lg[d + u];
            e = exp_dq(r, u);
            cmp_b("dq_oe_n", r.bc && u > 3, s[22]);
            cmp_b("dqs_oe_n", 1'h0, s[21]);
            cmp_b("dqs", u % 2 == 0, s[20]);
            if (!(r.bc && u > 3))
                cmp_v("dq", {e[3:0], e}, s[19:0]);
        end
        for (int j = 1; j <= p && !prv; j++) begin
            cmp_b("pre_oe_n", 1'h0, ctl_u.lg[d - j][21]);
            cmp_b("pre_dqs", 1'h0, ctl_u.lg[d - j][20]);
        end
        if (!prv)
            cmp_b("pre_start", 1'h1, ctl_u.lg[d - p - 1][21]);
        cmp_b("after_oe_n", !nxt, ctl_u.lg[d + 8][22]);
    endtask

    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        rows[0]  = '{FMT_SERIAL, PAGE_ZERO, 2'h1, 1'h0, 1'h0, 1'h0};
        rows[1]  = '{FMT_PARALLEL, PAGE_ZERO, 2'h0, 1'h0, 1'h0, 1'h1};
        rows[2]  = '{FMT_STAGGER, PAGE_ZERO, 2'h0, 1'h0, 1'h0, 1'h0};
        rows[3]  = '{FMT_STAGGER, PAGE_ZERO, 2'h1, 1'h0, 1'h0, 1'h1};
        rows[4]  = '{FMT_STAGGER, PAGE_ZERO, 2'h2, 1'h0, 1'h0, 1'h0};
        rows[5]  = '{FMT_STAGGER, PAGE_ZERO, 2'h3, 1'h0, 1'h0, 1'h0};
        rows[6]  = '{FMT_RFU, PAGE_ZERO, 2'h2, 1'h0, 1'h0, 1'h0};
        rows[7]  = '{FMT_STAGGER, 2'h2, 2'h3, 1'h0, 1'h0, 1'h0};
        rows[8]  = '{FMT_SERIAL, PAGE_ZERO, 2'h3, 1'h1, 1'h0, 1'h0};
        rows[9]  = '{FMT_STAGGER, PAGE_ZERO, 2'h1, 1'h1, 1'h1, 1'h1};
        rows[10] = '{FMT_PARALLEL, PAGE_ZERO, 2'h0, 1'h1, 1'h1, 1'h0};
        repeat (12) @(negedge SYS_CLK);
        SRST = 1'h0;
        @(negedge SYS_CLK);
        cmp_b("core_ready", 1'h1, CORE_READY);
        cmp_b("dq_oe_n", 1'h1, DQ_OE_N);
        cmp_v("dq", 20'h0, {dq4, DQ_O});
        // A read with the enable bit clear must leave the bus alone
        ctl_u.rd(2'h0, 1'h0, 1'h0);
        c = ctl_u.cap_h;
        wait_h(c + 2 * RL + 12);
        for (int i = c; i < c + 2 * RL + 12; i++)
            cmp_b("idle_oe_n", 1'h1, ctl_u.lg[i][22]);
        $display("Test disabled read done");
        MPR_EN = 1'h1;
        repeat (4) @(negedge SYS_CLK);
        cmp_b("core_ready", 1'h0, CORE_READY);
        // Table of single reads
        foreach (rows[i]) begin
            RD_FMT = rows[i].fmt;
            PAGE   = rows[i].pg;
            PRE2   = rows[i].pre;
            ctl_u.rd(rows[i].ba, rows[i].bc, rows[i].a2);
            c = ctl_u.cap_h;
            wait_h(c + 2 * RL + 12);
            chk_burst(rows[i], c, 1'b0, 1'b0);
            $display("Test row %0d done", i);
        end
        // Four staggered reads four clocks apart, no gaps allowed
        RD_FMT = FMT_STAGGER;
        PAGE   = PAGE_ZERO;
        PRE2   = 1'h0;
        for (int k = 0; k < 4; k++) begin
            ctl_u.rd(2'(k), 1'h0, 1'h0);
            cb[k] = ctl_u.cap_h;
        end
        wait_h(cb[3] + 2 * RL + 12);
        for (int k = 0; k < 4; k++)
            chk_burst('{FMT_STAGGER, PAGE_ZERO, 2'(k), 1'h0, 1'h0, 1'h0}, cb[k], k > 0,
                      k < 3);
        $display("Test back to back done");
        // Mode exit: core stays blocked until the delay runs out
        @(negedge LINK_CK);
        MPR_EN = 1'h0;
        c = ctl_u.h;
        wait_h(c + 2 * MD - 1);
        cmp_b("core_ready", 1'h0, CORE_READY);
        repeat (6) @(negedge SYS_CLK);
        cmp_b("core_ready", 1'h1, CORE_READY);
        $display("Test mode exit done");
        // Reset in mid-burst releases the bus
        MPR_EN = 1'h1;
        RD_FMT = FMT_SERIAL;
        ctl_u.rd(2'h3, 1'h0, 1'h0);
        wait_h(ctl_u.cap_h + 2 * RL + 2);
        SRST = 1'h1;
        repeat (2) @(negedge SYS_CLK);
        cmp_b("dq_oe_n", 1'h1, DQ_OE_N);
        cmp_b("dqs_oe_n", 1'h1, DQS_OE_N);
        cmp_v("dq", 20'h0, {dq4, DQ_O});
        // Release again: the cut burst must not resume, the pipe was flushed
        SRST = 1'h0;
        c = ctl_u.h;
        wait_h(c + 12);
        for (int i = c; i < c + 12; i++)
            cmp_b("rst_oe_n", 1'h1, ctl_u.lg[i][22]);
        cmp_b("core_ready", 1'h0, CORE_READY);
        $display("Test mid reset done");
        conclude();
    end
endmodule

// File: verilog/mprf_lat_pipe.sv
/*
 * Read latency delay line, advanced once per link clock.
 * Assumes the caller supplies a one-cycle shift enable on the system clock.
 */
`timescale 1ns/1ps
module mprf_lat_pipe
    import mprf_pkg::*;
#(
    parameter int DEPTH = READ_LAT_DEF,
    parameter int W     = ENT_W
) (
    input  wire logic               clk,
    input  wire logic               srst,
    input  wire logic               shift_en,
    input  wire logic [W-1:0]       din,
    output logic      [DEPTH*W-1:0] taps
);

    typedef struct packed {
        logic [DEPTH*W-1:0] sr;
    } mprf_pipe_t;

    mprf_pipe_t q;
    mprf_pipe_t d;

    // Stage zero takes the new command, older entries move up one stage
    always_comb begin
        d = q;
        if (shift_en) begin
            d.sr = {q.sr[(DEPTH-1)*W-1:0], din};
        end
    end

    // Synchronous clear keeps stale reads from leaking out after reset
    always_ff @(posedge clk) begin
        if (srst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign taps = q.sr;

endmodule

// File: verilog/mprf_pkg.sv
/*
 * Shared constants for the multipurpose register readout formatter.
 * Assumes the mode register logic and the pattern storage live outside.
 */
//
// Function
// R1 - Normal core operations are allowed again once the mode set delay expires.
// R2 - Three readout formats exist: serial, parallel and staggered.
// R3 - Two-bit format code: 00 serial, 01 parallel, 10 staggered, 11 reserved.
// R4 - Register readout only while the mode register three enable bit is 1.
// R5 - Bank address bits one and zero pick pattern location zero to three.
// R6 - Mode register, sensor and error frame readout always use serial format.
// R7 - The four 8-bit calibration locations are readable in all formats; in parallel format the code reads location zero only.
// R8 - Data strobes run with register data, including the programmed preamble.
// R9 - Serial: same 8-bit sequence on every lane, leftmost bit first.
// R10 - Parallel: lane pattern of first unit interval repeats for whole burst.
// R11 - Parallel: only pattern location zero supplies the data.
// R12 - Controller never reads locations one to three in parallel format.
// R13 - Parallel on x4: first four bits only, leftmost bit on lane zero.
// R14 - Parallel on x16: same byte pattern on lower and upper byte.
// R15 - Staggered: lane n of a nibble carries location (k+n) mod 4.
// R16 - Staggered on x8 and wider: every nibble repeats the lower nibble.
// R17 - Staggered x8/x16 reads use the same location rotation as x4.
// R18 - Back-to-back reads give contiguous bursts with no idle clocks.
// R19 - Burst chop four drives only the chosen half, rest left undriven; the code still drives and toggles DQS there.
package mprf_pkg;

    // ****************************************************************
    // Readout format and page codes
    // ****************************************************************
    localparam logic [1:0] FMT_SERIAL   = 2'h0;
    localparam logic [1:0] FMT_PARALLEL = 2'h1;
    localparam logic [1:0] FMT_STAGGER  = 2'h2;
    localparam logic [1:0] FMT_RFU      = 2'h3;
    localparam logic [1:0] PAGE_ZERO    = 2'h0;

    // ****************************************************************
    // Latency pipe entry layout and burst timing
    // ****************************************************************
    localparam int         ENT_W        = 7;
    localparam int         ENT_VLD      = 6;
    localparam int         ENT_BC4      = 5;
    localparam int         ENT_A2       = 4;
    localparam int         ENT_BA_LO    = 2;
    localparam int         ENT_FMT_LO   = 0;
    localparam logic [2:0] UI_LAST      = 3'h7;
    localparam int         DQ_W_DEF     = 16;
    localparam int         READ_LAT_DEF = 11;   // Link clocks, read latency
    localparam int         MOD_DLY_DEF  = 24;   // Link clocks, mode set delay
    localparam logic [7:0] MOD_CNT_ZERO = 8'h00;

    typedef enum logic [1:0] {
        MPRF_IDLE,
        MPRF_PRE,
        MPRF_DATA
    } mprf_state_t;

endpackage

// File: verilog/mprf_readout.sv
/*
 * Multipurpose register readout formatter: serial, parallel, staggered.
 * Assumes pattern bytes and mode fields arrive static on the system clock,
 * and that link clock and command pins come from outside its domain.
 */
`timescale 1ns/1ps
module mprf_readout
    import mprf_pkg::*;
#(
    parameter int DQ_W     = DQ_W_DEF,
    parameter int READ_LAT = READ_LAT_DEF,
    parameter int MOD_DLY  = MOD_DLY_DEF
) (
    input  wire logic            SYS_CLK,
    input  wire logic            SRST,
    input  wire logic            LINK_CK,
    input  wire logic            RD_CMD,
    input  wire logic [1:0]      BANK_ADDR,
    input  wire logic            BC4,
    input  wire logic            A2,
    input  wire logic            MPR_EN,
    input  wire logic [1:0]      RD_FMT,
    input  wire logic [1:0]      PAGE,
    input  wire logic            PRE2,
    input  wire logic [7:0]      LOC0,
    input  wire logic [7:0]      LOC1,
    input  wire logic [7:0]      LOC2,
    input  wire logic [7:0]      LOC3,
    output logic      [DQ_W-1:0] DQ_O,
    output logic                 DQ_OE_N,
    output logic                 DQS_O,
    output logic                 DQS_OE_N,
    output logic                 CORE_READY
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [2:0]      lk;       // Link clock sync, then edge history
        logic [4:0]      cs1;      // Command pin sync, first stage
        logic [4:0]      cs2;
        mprf_state_t     st;
        logic [2:0]      ui;
        logic [1:0]      cur_k;
        logic            cur_bc4;
        logic            cur_a2;
        logic [1:0]      cur_fmt;
        logic [7:0]      mod_cnt;
        logic            ready;
        logic [DQ_W-1:0] dq;
        logic            dq_oe_n;
        logic            dqs;
        logic            dqs_oe_n;
        logic [1:0]      ofmt;     // Format and position of the driven UI
        logic [1:0]      ok;
        logic [2:0]      oui;
    } mprf_st_t;

    mprf_st_t             q;
    mprf_st_t             d;
    logic                 rise;
    logic                 fall;
    logic [ENT_W-1:0]     din;
    logic [READ_LAT*ENT_W-1:0] taps;
    logic [ENT_W-1:0]     tap_start;
    logic [ENT_W-1:0]     tap_pre;
    logic [31:0]          locs;
    logic [1:0]           fmt_sel;

    // ****************************************************************
    // Lane pattern for one unit interval
    // ****************************************************************
    function automatic logic [DQ_W-1:0] lane_bits(input logic [1:0]  fmt,
                                                  input logic [1:0]  k,
                                                  input logic [2:0]  ui,
                                                  input logic [31:0] lv);
        logic [DQ_W-1:0] r;
        logic [1:0]      loc;
        r   = '0;
        loc = 2'h0;
        for (int i = 0; i < DQ_W; i++) begin
            case (fmt)
                FMT_PARALLEL: begin
                    r[i] = lv[7 - (i % 8)];               // R10 R11 R13 R14
                end
                FMT_STAGGER: begin
                    loc  = k + 2'(i % 4);                 // R15 R16 R17
                    r[i] = lv[{loc, ~ui}];
                end
                default: begin
                    r[i] = lv[{k, ~ui}];                  // R9
                end
            endcase
        end
        return r;
    endfunction

    // ****************************************************************
    // Command capture and read latency
    // ****************************************************************
    assign rise    = q.lk[1] & ~q.lk[2];
    assign fall    = ~q.lk[1] & q.lk[2];
    assign locs    = {LOC3, LOC2, LOC1, LOC0};
    // Non-zero pages hold mode data, and the reserved code falls back too
    assign fmt_sel = (PAGE != PAGE_ZERO || RD_FMT == FMT_RFU) ? FMT_SERIAL
                                                              : RD_FMT;   // R3 R6
    // Reads only enter while the enable bit is set; fields packed per ENT_* layout
    assign din     = {q.cs2[4] & MPR_EN, q.cs2[1:0], q.cs2[3:2], fmt_sel}; // R4 R5

    mprf_lat_pipe #(
        .DEPTH (READ_LAT),
        .W     (ENT_W)
    ) u_pipe (
        .clk      (SYS_CLK),
        .srst     (SRST),
        .shift_en (rise),
        .din      (din),
        .taps     (taps)
    );

    // Preamble tap sits one or two link clocks ahead of the data tap
    assign tap_start = taps[(READ_LAT-1)*ENT_W +: ENT_W];
    assign tap_pre   = PRE2 ? taps[(READ_LAT-3)*ENT_W +: ENT_W]
                            : taps[(READ_LAT-2)*ENT_W +: ENT_W];

    // ****************************************************************
    // Burst sequencer and output formatting
    // ****************************************************************
    always_comb begin
        logic       load;
        logic       drive;
        logic [2:0] ui_eff;
        load   = 1'b0;
        drive  = 1'b0;
        ui_eff = 3'h0;
        d      = q;
        d.lk   = {q.lk[1:0], LINK_CK};
        d.cs1  = {RD_CMD, BANK_ADDR, BC4, A2};
        d.cs2  = q.cs1;
        case (q.st)
            MPRF_IDLE: begin
                if (rise && tap_start[ENT_VLD]) begin
                    load = 1'b1;
                end else if (rise && tap_pre[ENT_VLD]) begin
                    d.st = MPRF_PRE;                                       // R8
                end
            end
            MPRF_PRE: begin
                if (rise && tap_start[ENT_VLD]) begin
                    load = 1'b1;
                end
            end
            MPRF_DATA: begin
                if (rise && q.ui == UI_LAST) begin
                    // Next burst follows at once when its slot is due
                    if (tap_start[ENT_VLD]) begin
                        load = 1'b1;                                       // R18
                    end else if (tap_pre[ENT_VLD]) begin
                        d.st = MPRF_PRE;
                    end else begin
                        d.st = MPRF_IDLE;
                    end
                end else if (rise || fall) begin
                    d.ui = q.ui + 3'h1;
                end
            end
            default: begin
                d.st = MPRF_IDLE;
            end
        endcase
        if (load) begin
            d.st      = MPRF_DATA;
            d.ui      = 3'h0;
            d.cur_k   = tap_start[ENT_BA_LO +: 2];
            d.cur_bc4 = tap_start[ENT_BC4];
            d.cur_a2  = tap_start[ENT_A2];
            d.cur_fmt = tap_start[ENT_FMT_LO +: 2];
        end
        // Chopped bursts pick their half by A2; DQ stays quiet afterwards while DQS keeps toggling
        ui_eff     = d.cur_bc4 ? {d.cur_a2, d.ui[1:0]} : d.ui;
        drive      = (d.st == MPRF_DATA) && !(d.cur_bc4 && d.ui[2]);        // R19
        d.dq       = drive ? lane_bits(d.cur_fmt, d.cur_k, ui_eff, locs)
                           : '0;                                           // R2 R7
        d.dq_oe_n  = !drive;
        d.dqs_oe_n = (d.st == MPRF_IDLE);                                  // R8
        d.dqs      = (d.st == MPRF_DATA) && !d.ui[0];
        d.ofmt     = d.cur_fmt;
        d.ok       = d.cur_k;
        d.oui      = ui_eff;
        // Core access waits out the mode set delay, counted in link clocks
        if (MPR_EN) begin
            d.mod_cnt = 8'(MOD_DLY);
        end else if (rise && q.mod_cnt != MOD_CNT_ZERO) begin
            d.mod_cnt = q.mod_cnt - 8'h01;
        end
        d.ready = !MPR_EN && d.mod_cnt == MOD_CNT_ZERO;                    // R1
    end

    // Reset leaves every pin released and the core ready
    always_ff @(posedge SYS_CLK) begin
        if (SRST) begin
            q          <= '0;
            q.dq_oe_n  <= 1'b1;
            q.dqs_oe_n <= 1'b1;
            q.ready    <= 1'b1;
        end else begin
            q <= d;
        end
    end

    assign DQ_O       = q.dq;
    assign DQ_OE_N    = q.dq_oe_n;
    assign DQS_O      = q.dqs;
    assign DQS_OE_N   = q.dqs_oe_n;
    assign CORE_READY = q.ready;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (SRST);

    logic on_ser;
    logic on_par;
    logic on_stg;
    logic stg_lane1;
    assign on_ser    = !q.dq_oe_n && q.ofmt == FMT_SERIAL;
    assign on_par    = !q.dq_oe_n && q.ofmt == FMT_PARALLEL;
    assign on_stg    = !q.dq_oe_n && q.ofmt == FMT_STAGGER;
    assign stg_lane1 = locs[{q.ok + 2'h1, ~q.oui}];

    sequence s_last_ui;
        rise && q.st == MPRF_DATA && q.ui == UI_LAST;
    endsequence
    sequence s_none_due;
        !tap_start[ENT_VLD] && !tap_pre[ENT_VLD];
    endsequence

    AST_READY_HELD_OFF: assert property ( // R1
        $fell(MPR_EN) ##1 (!MPR_EN) [*7] |-> !CORE_READY)
        else $error("core ready before mode set delay elapsed");
    AST_NO_READ_OUTSIDE: assert property ( // R4
        rise && !MPR_EN |=> !taps[ENT_VLD])
        else $error("read captured while readout disabled");
    AST_PAGE_SERIAL: assert property ( // R6
        !DQ_OE_N && PAGE != PAGE_ZERO |-> q.ofmt == FMT_SERIAL)
        else $error("mode page read not in serial format");
    AST_STROBE_WITH_DATA: assert property ( // R8
        !DQ_OE_N |-> !DQS_OE_N)
        else $error("data driven without strobe");
    AST_SERIAL_ALL_LANES: assert property ( // R9
        on_ser |-> DQ_O == {DQ_W{DQ_O[0]}} && DQ_O[0] == locs[{q.ok, ~q.oui}])
        else $error("serial lanes differ or wrong bit");
    AST_PARALLEL_LOC0: assert property ( // R11
        on_par |-> DQ_O[3:0] == {LOC0[4], LOC0[5], LOC0[6], LOC0[7]})
        else $error("parallel lanes not from location zero");
    AST_STAGGER_ROTATE: assert property ( // R15
        on_stg |-> DQ_O[1] == stg_lane1)
        else $error("staggered lane one has wrong location");
    AST_BURST_CONTIGUOUS: assert property ( // R18
        s_last_ui ##0 tap_start[ENT_VLD] |=> q.st == MPRF_DATA && q.ui == 3'h0)
        else $error("gap between back-to-back bursts");
    AST_BURST_END_IDLE: assert property ( // R18
        s_last_ui ##0 s_none_due |=> q.st == MPRF_IDLE)
        else $error("burst did not end after eight unit intervals");
    AST_BC4_RELEASE: assert property ( // R19
        q.st == MPRF_DATA && q.cur_bc4 && q.ui[2] |-> DQ_OE_N)
        else $error("chopped burst drove second half");

    if (DQ_W == 16) begin : g_x16
        AST_X16_BYTES: assert property ( // R14
            on_par |-> DQ_O[15:8] == DQ_O[7:0])
            else $error("parallel upper byte differs from lower");
    end
    if (DQ_W >= 8) begin : g_x8
        AST_NIBBLE_REPEAT: assert property ( // R16
            on_stg |-> DQ_O[7:4] == DQ_O[3:0])
            else $error("staggered upper nibble differs");
    end

endmodule
